// File: dmc_pkg.sv
// Package with register layout, field positions and timing constants for the mode register block
`default_nettype none
package dmc_pkg;
    localparam logic [7:0]  DEVICE_MODE_CONFIG_OFS = 8'hd1;
    localparam logic [7:0]  UNIT_SERIAL_TEXT_OFS   = 8'h9e;
    localparam logic [15:0] MODE_RESET_VAL         = 16'h0000;
    localparam logic [15:0] MODE_WRITE_MASK        = 16'hfcdc;
    localparam int          ROLE_HI                = 15;
    localparam int          ROLE_LO                = 14;
    localparam int          ALERT_BIT              = 13;
    localparam int          SEQ_BIT                = 12;
    localparam int          SRST_BIT               = 11;
    localparam int          LOCK_BIT               = 10;
    localparam int          ADCT_HI                = 7;
    localparam int          ADCT_LO                = 6;
    localparam int          FIGN_BIT               = 4;
    localparam int          AVG_HI                 = 3;
    localparam int          AVG_LO                 = 2;
    localparam int          CLK_MHZ                = 20;
    localparam int          GUARD_WINDOW_MS        = 8;
    localparam int          GUARD_WINDOW_CYC       = GUARD_WINDOW_MS * 1000 * CLK_MHZ;
    localparam int          GUARD_CNT_W            = 18;
    localparam logic [31:0] PASSWORD_RESET_VAL     = 32'h3130_3130;
    localparam int          LOCK_LIMIT             = 256;
    localparam logic [1:0]  ROLE_SINGLE            = 2'h0;
    localparam logic [1:0]  ROLE_SLAVE             = 2'h1;
    localparam logic [1:0]  ROLE_MASTER_LATCH      = 2'h2;
    localparam logic [1:0]  ROLE_MASTER_RETRY      = 2'h3;
    localparam logic [3:0]  HOST_STAT_OFS          = 4'h0;
    localparam logic [3:0]  HOST_CMD_OFS           = 4'h1;
    localparam logic [3:0]  HOST_DATA_OFS          = 4'h2;
    localparam logic [3:0]  HOST_RDATA_OFS         = 4'h3;
    localparam logic [3:0]  HOST_LOCKCNT_OFS       = 4'h4;
    localparam logic [3:0]  HOST_OFS_RESET         = 4'h0;
endpackage : dmc_pkg
`default_nettype wire

// File: dmc_if.sv
// Interface joining the host end and the device end of the mode register access path
`timescale 1ns/1ns
`default_nettype none
interface dmc_if;
    logic        req;
    logic        wr;
    logic [7:0]  cmd;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;
    logic        alert_n;
    modport device (input req, input wr, input cmd, input wdata, output rdata, output ack,
                    output alert_n);
    modport host (output req, output wr, output cmd, output wdata, input rdata, input ack,
                  input alert_n);
endinterface : dmc_if
`default_nettype wire

// File: dmc_device.sv
// Device end: mode configuration register, guarded actions and password lock
//
// Contract
// - Bits 15:14 decode the group sequencing role
// - Host avoids cascaded secondary group across devices; the host forwards the role bits 15:14 without any check
// - Alert works only while bit 13 set
// - Bit 12 picks time or event sequencing
// - Soft reset on 1,0,1 within 8 ms
// - Lock on 1,0,1 within 8 ms
// - Correct password unlock clears lock bit
// - Host locks/unlocks at most 256 times; the host counts only lock-bit mode writes, not unlocks
// - Bits 9:8 and 5 read as zero
// - Bits 7:6 set conversion time 1-8 us
// - Host avoids rewrites while supplies operate
// - Bit 4 gates fault input shutdown
// - Bits 3:2 set averaging 1-8 samples
// - Upper serial bytes are the password
`timescale 1ns/1ns
`default_nettype none
module dmc_device (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    dmc_if.device            bus,
    input  wire logic        fault_pin_n,
    input  wire logic        alert_event,
    input  wire logic        unlock_req,
    input  wire logic [31:0] unlock_key,
    output logic [1:0]       group_sequencing_role,
    output logic             cascade_master,
    output logic             cascade_retry,
    output logic             cascade_slave,
    output logic             sequencing_method_select,
    output logic [3:0]       adc_time_us,
    output logic [3:0]       avg_samples,
    output logic             global_shutdown,
    output logic             soft_reset_pulse,
    output logic             locked
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] mode_ff;
    logic [15:0] nxt_mode;
    logic [63:0] serial_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic        alert_n_ff;
    logic        lock_state_ff;
    logic        srst_ff;
    logic [1:0]  fault_sync_ff;
    logic        wr_mode;
    logic        wr_serial;
    logic [1:0]  guard_fire;

    assign wr_mode   = bus.req && bus.wr && (bus.cmd == dmc_pkg::DEVICE_MODE_CONFIG_OFS);
    assign wr_serial = bus.req && bus.wr && (bus.cmd == dmc_pkg::UNIT_SERIAL_TEXT_OFS);

    ////////////////////////////////////////////////////////////////////////
    // One guard detector per action bit: 0 soft reset, 1 lock
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_guard
            localparam int BITPOS = (g == 0) ? dmc_pkg::SRST_BIT : dmc_pkg::LOCK_BIT;
            logic [1:0]                   stage_ff;
            logic [dmc_pkg::GUARD_CNT_W-1:0] cnt_ff;
            logic                         wbit;
            logic                         expired;
            assign wbit    = bus.wdata[BITPOS];
            assign expired = (cnt_ff == dmc_pkg::GUARD_CNT_W'(dmc_pkg::GUARD_WINDOW_CYC));
            assign guard_fire[g] = wr_mode && wbit && (stage_ff == 2'h2) && !expired;
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    stage_ff <= 2'h0;
                    cnt_ff   <= '0;
                end else if (wr_mode && (stage_ff == 2'h0 || expired) && wbit) begin
                    stage_ff <= 2'h1;
                    cnt_ff   <= '0;
                end else if (expired || guard_fire[g]) begin
                    stage_ff <= 2'h0;
                    cnt_ff   <= '0;
                end else if (stage_ff != 2'h0) begin
                    cnt_ff <= cnt_ff + 1'b1;
                    if (wr_mode && stage_ff == 2'h1 && !wbit)
                        stage_ff <= 2'h2;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_mode = mode_ff;
        if (wr_mode)
            nxt_mode = bus.wdata[15:0] & dmc_pkg::MODE_WRITE_MASK;
        if (unlock_req && lock_state_ff && unlock_key == serial_ff[63:32])
            nxt_mode[dmc_pkg::LOCK_BIT] = 1'b0;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_ff   <= dmc_pkg::MODE_RESET_VAL;
            serial_ff <= {dmc_pkg::PASSWORD_RESET_VAL, dmc_pkg::PASSWORD_RESET_VAL};
        end else if (srst_ff) begin
            mode_ff   <= dmc_pkg::MODE_RESET_VAL;
        end else begin
            mode_ff <= nxt_mode;
            if (wr_serial)
                serial_ff <= {bus.wdata, serial_ff[31:0]};
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lock_state_ff <= 1'b0;
            srst_ff       <= 1'b0;
        end else begin
            srst_ff <= guard_fire[0];
            if (srst_ff)
                lock_state_ff <= 1'b0;
            else if (guard_fire[1])
                lock_state_ff <= 1'b1;
            else if (unlock_req && lock_state_ff && unlock_key == serial_ff[63:32])
                lock_state_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ack_ff        <= 1'b0;
            rdata_ff      <= '0;
            alert_n_ff    <= 1'b1;
            fault_sync_ff <= 2'h3;
        end else begin
            ack_ff        <= bus.req;
            fault_sync_ff <= {fault_sync_ff[0], fault_pin_n};
            alert_n_ff    <= !(alert_event && mode_ff[dmc_pkg::ALERT_BIT]);
            if (bus.req && !bus.wr)
                rdata_ff <= (bus.cmd == dmc_pkg::DEVICE_MODE_CONFIG_OFS)
                            ? {16'h0000, mode_ff} : 32'h0000_0000;
        end
    end

    assign bus.ack     = ack_ff;
    assign bus.rdata   = rdata_ff;
    assign bus.alert_n = alert_n_ff;

    assign group_sequencing_role    = mode_ff[dmc_pkg::ROLE_HI:dmc_pkg::ROLE_LO];
    assign cascade_slave  = (group_sequencing_role == dmc_pkg::ROLE_SLAVE);
    assign cascade_master = (group_sequencing_role == dmc_pkg::ROLE_MASTER_LATCH) ||
                            (group_sequencing_role == dmc_pkg::ROLE_MASTER_RETRY);
    assign cascade_retry  = (group_sequencing_role == dmc_pkg::ROLE_MASTER_RETRY);
    assign sequencing_method_select = mode_ff[dmc_pkg::SEQ_BIT];
    assign adc_time_us = 4'h1 << mode_ff[dmc_pkg::ADCT_HI:dmc_pkg::ADCT_LO];
    assign avg_samples = 4'h1 << mode_ff[dmc_pkg::AVG_HI:dmc_pkg::AVG_LO];
    assign global_shutdown  = !fault_sync_ff[1] && !mode_ff[dmc_pkg::FIGN_BIT];
    assign soft_reset_pulse = srst_ff;
    assign locked           = lock_state_ff;
endmodule : dmc_device
`default_nettype wire

// File: dmc_host.sv
// Host end: issues register commands from a local software port
`timescale 1ns/1ns
`default_nettype none
module dmc_host (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    dmc_if.host              bus,
    input  wire logic [3:0]  sw_addr,
    input  wire logic [31:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [31:0]      sw_rdata,
    input  wire logic        supplies_on
);
    ////////////////////////////////////////////////////////////////////////
    logic        req_ff;
    logic        wr_ff;
    logic [7:0]  cmd_ff;
    logic [31:0] wdata_ff;
    logic [31:0] data_ff;
    logic [31:0] last_rd_ff;
    logic [31:0] sw_rdata_ff;
    logic        busy_ff;
    logic        refused_ff;
    logic [8:0]  lock_cnt_ff;
    logic        go;
    logic        is_mode;
    logic        lock_write;

    assign go      = sw_wr && (sw_addr == dmc_pkg::HOST_CMD_OFS) && !busy_ff;
    assign is_mode = (sw_wdata[7:0] == dmc_pkg::DEVICE_MODE_CONFIG_OFS);
    // Mode writes are dropped while supplies run; lock-bit mode writes are also dropped once the lock budget is spent
    assign lock_write = data_ff[dmc_pkg::LOCK_BIT];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            req_ff      <= 1'b0;
            wr_ff       <= 1'b0;
            cmd_ff      <= 8'h00;
            wdata_ff    <= '0;
            data_ff     <= '0;
            last_rd_ff  <= '0;
            busy_ff     <= 1'b0;
            refused_ff  <= 1'b0;
            lock_cnt_ff <= 9'h000;
            sw_rdata_ff <= '0;
        end else begin
            req_ff <= 1'b0;
            if (sw_wr && sw_addr == dmc_pkg::HOST_DATA_OFS)
                data_ff <= sw_wdata;
            if (go) begin
                if (sw_wdata[8] && is_mode &&
                    (supplies_on || (lock_write &&
                     lock_cnt_ff >= 9'(dmc_pkg::LOCK_LIMIT)))) begin
                    refused_ff <= 1'b1;
                end else begin
                    req_ff     <= 1'b1;
                    wr_ff      <= sw_wdata[8];
                    cmd_ff     <= sw_wdata[7:0];
                    wdata_ff   <= data_ff;
                    busy_ff    <= 1'b1;
                    refused_ff <= 1'b0;
                    if (sw_wdata[8] && is_mode && lock_write)
                        lock_cnt_ff <= lock_cnt_ff + 9'h001;
                end
            end
            if (bus.ack) begin
                busy_ff <= 1'b0;
                if (!wr_ff)
                    last_rd_ff <= bus.rdata;
            end
            if (sw_rd) begin
                case (sw_addr)
                    dmc_pkg::HOST_STAT_OFS:
                        sw_rdata_ff <= {29'h0, !bus.alert_n, refused_ff, busy_ff};
                    dmc_pkg::HOST_DATA_OFS:    sw_rdata_ff <= data_ff;
                    dmc_pkg::HOST_RDATA_OFS:   sw_rdata_ff <= last_rd_ff;
                    dmc_pkg::HOST_LOCKCNT_OFS: sw_rdata_ff <= {23'h0, lock_cnt_ff};
                    default:                   sw_rdata_ff <= 32'h0;
                endcase
            end
        end
    end

    assign bus.req   = req_ff;
    assign bus.wr    = wr_ff;
    assign bus.cmd   = cmd_ff;
    assign bus.wdata = wdata_ff;
    assign sw_rdata  = sw_rdata_ff;
endmodule : dmc_host
`default_nettype wire

// File: dmc_props.sv
// Checker on the link between the host end and the device end
`timescale 1ns/1ns
`default_nettype none
module dmc_props (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        req,
    input wire logic        wr,
    input wire logic [7:0]  cmd,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        ack,
    input wire logic        alert_n
);
    logic [15:0] shadow_ff;
    logic        alert_en_ff;
    logic [1:0]  off_cnt_ff;
    wire         mode_wr = req && wr && (cmd == dmc_pkg::DEVICE_MODE_CONFIG_OFS);
    wire  [1:0]  off_inc = (off_cnt_ff == 2'h3) ? 2'h3 : off_cnt_ff + 2'h1;
    // Last mode value sent, and cycles since alerts were last turned off
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            shadow_ff   <= dmc_pkg::MODE_RESET_VAL;
            alert_en_ff <= 1'b0;
            off_cnt_ff  <= 2'h0;
        end else begin
            if (mode_wr) begin
                shadow_ff   <= wdata[15:0];
                alert_en_ff <= wdata[dmc_pkg::ALERT_BIT];
            end
            off_cnt_ff <= alert_en_ff ? 2'h0 : off_inc;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_mode_read;
        req && !wr && (cmd == dmc_pkg::DEVICE_MODE_CONFIG_OFS);
    endsequence
    sequence s_answer;
        ack ##1 !ack;
    endsequence
    a_ack_follows_req: assert property (req |=> s_answer)
        else $error("ack not a single pulse after request");
    a_no_stray_ack: assert property (ack |-> $past(req))
        else $error("ack without request");
    a_single_request: assert property (req |=> !req)
        else $error("second request while one is open");
    a_reserved_zero:
        assert property (s_mode_read |=> rdata[9:8] == 2'h0 && !rdata[5] && rdata[1:0] == 2'h0)
        else $error("reserved mode bits read nonzero");
    a_upper_zero: assert property (s_mode_read |=> rdata[31:16] == 16'h0)
        else $error("mode read has upper bits set");
    a_mode_readback:
        assert property (s_mode_read |=> (rdata[15:0] & 16'hf0dc) == (shadow_ff & 16'hf0dc))
        else $error("mode field read back differs from written");
    a_alert_disabled: assert property (off_cnt_ff == 2'h3 |-> alert_n)
        else $error("alert driven while disabled");
    a_quiet_on_ack: assert property (ack |-> !req)
        else $error("request during answer");
endmodule : dmc_props
`default_nettype wire

// File: dmc_tb_top.sv
// Testbench driving the host software port and the device side pins
`timescale 1ns/1ns
`default_nettype none
module dmc_tb_top;
    logic        core_clk = 1'b0, nrst = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
    logic        supplies_on = 1'b0, fault_pin_n = 1'b1, alert_event = 1'b0;
    logic        unlock_req = 1'b0, c_master, c_retry, c_slave, seq_sel, shutdown;
    logic        srst_pulse, locked;
    logic [3:0]  sw_addr = 4'h0, adc_us, avg_n;
    logic [31:0] sw_wdata = 32'h0, unlock_key = 32'h0, sw_rdata, v;
    logic [1:0]  role;
    int          fails = 0, compares = 0, srst_seen = 0;
    localparam logic [31:0] NEW_KEY = 32'h5a5a_c3c3;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (srst_pulse === 1'b1) srst_seen <= srst_seen + 1;
    dmc_if dmc_if_inst ();
    dmc_device dmc_device_inst (.core_clk(core_clk), .nrst(nrst), .bus(dmc_if_inst.device),
        .fault_pin_n(fault_pin_n), .alert_event(alert_event), .unlock_req(unlock_req),
        .unlock_key(unlock_key), .group_sequencing_role(role), .cascade_master(c_master),
        .cascade_retry(c_retry), .cascade_slave(c_slave), .sequencing_method_select(seq_sel),
        .adc_time_us(adc_us), .avg_samples(avg_n), .global_shutdown(shutdown),
        .soft_reset_pulse(srst_pulse), .locked(locked));
    dmc_host dmc_host_inst (.core_clk(core_clk), .nrst(nrst), .bus(dmc_if_inst.host),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .supplies_on(supplies_on));
    dmc_props dmc_props_inst (.core_clk(core_clk), .nrst(nrst), .req(dmc_if_inst.req),
        .wr(dmc_if_inst.wr), .cmd(dmc_if_inst.cmd), .wdata(dmc_if_inst.wdata),
        .rdata(dmc_if_inst.rdata), .ack(dmc_if_inst.ack), .alert_n(dmc_if_inst.alert_n));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask : chk
    task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge core_clk);
        sw_wr    <= 1'b0;
    endtask : sw_write
    task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge core_clk);
        sw_rd   <= 1'b0;
        #1 d = sw_rdata;
    endtask : sw_read
    // Device register access through the host, polled until not busy
    task automatic host_cmd(input logic w, input logic [7:0] c, input logic [31:0] d);
        logic [31:0] s;
        s = 32'h1;
        sw_write(dmc_pkg::HOST_DATA_OFS, d);
        sw_write(dmc_pkg::HOST_CMD_OFS, {23'h0, w, c});
        for (int i = 0; i < 20 && s[0] !== 1'b0; i++) sw_read(dmc_pkg::HOST_STAT_OFS, s);
        chk("host busy", 32'h0, {31'h0, s[0]});
    endtask : host_cmd
    task automatic dev_cmd(input logic w, input logic [15:0] d);
        host_cmd(w, dmc_pkg::DEVICE_MODE_CONFIG_OFS, {16'h0, d});
    endtask : dev_cmd
    task automatic mode_rd(output logic [31:0] d);
        dev_cmd(1'b0, 16'h0);
        sw_read(dmc_pkg::HOST_RDATA_OFS, d);
    endtask : mode_rd
    task automatic unlock(input logic [31:0] k);
        @(posedge core_clk);
        unlock_key <= k;
        unlock_req <= 1'b1;
        @(posedge core_clk);
        unlock_req <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : unlock
    task automatic end_sim;
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10000) @(posedge core_clk);
        fails++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        mode_rd(v);
        chk("mode reset", {16'h0, dmc_pkg::MODE_RESET_VAL}, v);
        // Every field code, reserved bits written as ones
        for (int i = 0; i < 4; i++) begin
            dev_cmd(1'b1, {i[1:0], 1'b1, i[0], 4'h3, i[1:0], 1'b1, i[1], i[1:0], 2'h3});
            mode_rd(v);
            chk("mode", {16'h0, i[1:0], 1'b1, i[0], 4'h0, i[1:0], 1'b0, i[1], i[1:0], 2'h0}, v);
            chk("role", 32'(i), {30'h0, role});
            chk("cascade", {29'h0, i[1], i == 3, i == 1}, {29'h0, c_master, c_retry, c_slave});
            chk("seq method", {31'h0, i[0]}, {31'h0, seq_sel});
            chk("adc time", 32'h1 << i, {28'h0, adc_us});
            chk("averaging", 32'h1 << i, {28'h0, avg_n});
        end
        fault_pin_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk("fault ignored", 32'h0, {31'h0, shutdown});
        dev_cmd(1'b1, 16'h0);
        repeat (5) @(posedge core_clk);
        chk("fault shutdown", 32'h1, {31'h0, shutdown});
        fault_pin_n <= 1'b1;
        alert_event <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("alert off", 32'h1, {31'h0, dmc_if_inst.alert_n});
        dev_cmd(1'b1, 16'h2000);
        repeat (3) @(posedge core_clk);
        chk("alert on", 32'h0, {31'h0, dmc_if_inst.alert_n});
        sw_read(dmc_pkg::HOST_STAT_OFS, v);
        chk("alert status", 32'h1, {31'h0, v[2]});
        alert_event <= 1'b0;
        supplies_on <= 1'b1;
        dev_cmd(1'b1, 16'h3000);
        sw_read(dmc_pkg::HOST_STAT_OFS, v);
        chk("refused", 32'h1, {31'h0, v[1]});
        supplies_on <= 1'b0;
        mode_rd(v);
        chk("mode kept", 32'h2000, v);
        dev_cmd(1'b1, 16'h0800);
        dev_cmd(1'b1, 16'h0000);
        dev_cmd(1'b1, 16'h0800);
        chk("soft resets", 32'h1, srst_seen);
        // New password in the upper serial bytes; the lower bytes keep the old text
        host_cmd(1'b1, dmc_pkg::UNIT_SERIAL_TEXT_OFS, NEW_KEY);
        dev_cmd(1'b1, 16'h0400);
        dev_cmd(1'b1, 16'h0000);
        dev_cmd(1'b1, 16'h0400);
        chk("locked", 32'h1, {31'h0, locked});
        unlock(dmc_pkg::PASSWORD_RESET_VAL);
        chk("bad key", 32'h1, {31'h0, locked});
        unlock(NEW_KEY);
        chk("unlocked", 32'h0, {31'h0, locked});
        mode_rd(v);
        chk("lock bit", 32'h0, {31'h0, v[dmc_pkg::LOCK_BIT]});
        // Spend the rest of the lock budget, then one more lock write is refused
        for (int k = 0; k < 254; k++) dev_cmd(1'b1, 16'h0400);
        dev_cmd(1'b1, 16'h0400);
        sw_read(dmc_pkg::HOST_STAT_OFS, v);
        chk("lock budget refused", 32'h1, {31'h0, v[1]});
        sw_read(dmc_pkg::HOST_LOCKCNT_OFS, v);
        chk("lock count", 32'(dmc_pkg::LOCK_LIMIT), v);
        end_sim();
    end
endmodule : dmc_tb_top
`default_nettype wire
